// *** shared_ram_lock_station_sap_lists.sv ***
// ram lock cell, active station list and service point list
`timescale 1ns/1ps
`include "sram_lock_map.svh"
module shared_ram_lock_station_sap_lists #(
  parameter int STATIONS = 127,
  parameter int SAPS = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host parallel port
  input wire logic [9:0] host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  // sequencer lock
  input wire logic seq_lock_req,
  output logic seq_lock_grant,
  // sequencer station update
  input wire logic stn_valid,
  input wire logic [6:0] stn_addr,
  input wire logic stn_in_ring,
  input wire logic stn_fcb,
  input wire logic stn_fcv,
  // sequencer header check
  input wire logic hdr_valid,
  input wire logic [6:0] hdr_sap,
  input wire logic hdr_default,
  input wire logic [7:0] hdr_src_addr,
  input wire logic hdr_queue_full,
  input wire logic [5:0] sap_max,
  output logic resp_valid,
  output sram_lock_pkg::resp_code_t resp_code,
  // sequencer indication done
  input wire logic ind_valid,
  input wire logic [5:0] ind_sap,
  input wire logic ind_default,
  input wire logic ind_supported,
  output logic [7:0] ind_wp,
  // events towards the host interrupt logic
  output logic las_change_evt,
  output logic ind_evt
);

  localparam int ENTRIES = SAPS + 1;

  // refuse sizes the address map cannot hold
  if (STATIONS < 1 || STATIONS > 127)
    $error("STATIONS must be 1..127");
  if (SAPS < 1 || SAPS > 64)
    $error("SAPS must be 1..64");

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // list index of a service point; default point sits first
  function automatic logic [6:0] sap_slot(input logic dflt,
                                          input logic [5:0] num);
    sap_slot = dflt ? 7'h00 : (7'(num) + 7'h01);
  endfunction

  // control byte after one cycle of events, events win over host data
  function automatic logic [7:0] ctrl_next(input logic [7:0] cur,
    input logic hwr, input logic [7:0] hdata, input logic inc,
    input logic hdr, input logic [7:0] hval, input logic dec);
    logic [7:0] v;
    v = cur;
    if (hwr)
      v = hdata;
    if (hdr)
      v = hval;
    if (dec)
      v[`CTRL_IN_USE_BIT] = 1'b0;
    if (inc && !dec && v[2:0] != `CTRL_COUNT_MAX)
      v[2:0] = v[2:0] + 3'h1;
    else if (dec && !inc && v[2:0] != 3'h0)
      v[2:0] = v[2:0] - 3'h1;
    ctrl_next = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // host pin synchronisers; strobes need a third stage for edges

  logic [9:0] addr_s1_q;
  logic [9:0] addr_s2_q;
  logic [7:0] wdata_s1_q;
  logic [7:0] wdata_s2_q;
  logic [1:0] strb_s1_q;
  logic [1:0] strb_s2_q;
  logic [1:0] strb_s3_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      addr_s1_q <= 10'h000;
      addr_s2_q <= 10'h000;
      wdata_s1_q <= 8'h00;
      wdata_s2_q <= 8'h00;
      strb_s1_q <= 2'h3;
      strb_s2_q <= 2'h3;
      strb_s3_q <= 2'h3;
    end
    else
    begin
      addr_s1_q <= host_addr;
      addr_s2_q <= addr_s1_q;
      wdata_s1_q <= host_data_in;
      wdata_s2_q <= wdata_s1_q;
      strb_s1_q <= {host_wr_n, host_rd_n};
      strb_s2_q <= strb_s1_q;
      strb_s3_q <= strb_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host address decode

  wire rd_evt = strb_s3_q[0] && !strb_s2_q[0];
  wire wr_evt = strb_s3_q[1] && !strb_s2_q[1];
  wire is_lock = (addr_s2_q == `LOCK_CELL_ADDR);
  wire is_status = (addr_s2_q == `STATUS_ADDR);
  wire [9:0] las_off = addr_s2_q - `LAS_BASE_ADDR;
  wire is_las = (addr_s2_q >= `LAS_BASE_ADDR)
    && (las_off < 10'(STATIONS));
  wire [9:0] sap_off = addr_s2_q - `SAP_BASE_ADDR;
  wire is_sap = (addr_s2_q >= `SAP_BASE_ADDR)
    && (sap_off < 10'(ENTRIES * `SAP_ENTRY_BYTES));
  wire [6:0] sap_idx = 7'(sap_off / 10'(`SAP_ENTRY_BYTES));
  wire [1:0] sap_sel = 2'(sap_off % 10'(`SAP_ENTRY_BYTES));
  wire host_ctrl_wr = wr_evt && is_sap && (sap_sel == 2'h0);
  wire host_inc = host_ctrl_wr && (wdata_s2_q == `CTRL_INC_CODE);

  ////////////////////////////////////////////////////////////////////////////
  // lock cell

  logic host_lock;
  logic lock_value;

  // a read returning 0 takes the lock
  lock_arbiter u_arb (
    .ref_clk(ref_clk),
    .rst(rst),
    .lock_read(rd_evt && is_lock),
    .lock_write(wr_evt && is_lock),
    .seq_req(seq_lock_req),
    .seq_grant(seq_lock_grant),
    .host_lock(host_lock),
    .read_value(lock_value)
  );

  // sequencer changes the lists only while it owns the ram
  wire seq_stn = stn_valid && seq_lock_grant;
  wire seq_hdr = hdr_valid && seq_lock_grant;
  wire seq_ind = ind_valid && seq_lock_grant;

  ////////////////////////////////////////////////////////////////////////////
  // list storage

  logic [3:0] las_q [STATIONS];
  logic [7:0] ctrl_q [ENTRIES];
  logic [7:0] src_q [ENTRIES];
  logic [7:0] ptr_q [ENTRIES];

  ////////////////////////////////////////////////////////////////////////////
  // header check against the addressed entry

  wire [6:0] hdr_slot = hdr_default ? 7'h00 : (hdr_sap + 7'h01);
  wire hdr_in_range = (hdr_slot < 7'(ENTRIES));
  wire [7:0] hdr_ctrl = hdr_in_range ? ctrl_q[hdr_slot] : 8'h00;
  wire [7:0] hdr_exp = hdr_in_range ? src_q[hdr_slot] : `SRC_INACTIVE;
  wire [6:0] ind_slot = sap_slot(ind_default, ind_sap);
  sram_lock_pkg::resp_code_t chk_code;
  logic chk_wr;
  logic [7:0] chk_ctrl;

  sap_checker #(
    .SAPS(SAPS)
  ) u_chk (
    .ctrl(hdr_ctrl),
    .exp_src(hdr_exp),
    .sap_num(hdr_sap),
    .is_default(hdr_default),
    .src_addr(hdr_src_addr),
    .queue_full(hdr_queue_full),
    .sap_max(sap_max),
    .code(chk_code),
    .entry_wr(chk_wr),
    .new_ctrl(chk_ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // station list update; hardware change set wins over a host clear

  wire [6:0] las_idx = las_off[6:0];
  wire stn_ok = seq_stn && (stn_addr < 7'(STATIONS));
  wire stn_moved = stn_ok
    && (las_q[stn_addr][`LAS_STATE_BIT - 2] != stn_in_ring);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < STATIONS; i++)
        las_q[i] <= `LAS_RESET;
    end
    else
    begin
      for (int i = 0; i < STATIONS; i++)
      begin
        // host clears change bit by write
        if (wr_evt && is_las && las_idx == 7'(i)
            && !(stn_ok && stn_addr == 7'(i)))
          las_q[i] <= wdata_s2_q[5:2];
        else if (stn_ok && stn_addr == 7'(i))
          las_q[i] <= {stn_fcb, stn_fcv,
            las_q[i][1] | stn_moved
              | (wr_evt && is_las && las_idx == 7'(i) && wdata_s2_q[3]),
            stn_in_ring};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // service point list update

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        ctrl_q[i] <= `CTRL_RESET;
        src_q[i] <= `SRC_RESET;
        ptr_q[i] <= `PTR_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        ctrl_q[i] <= ctrl_next(ctrl_q[i],
          host_ctrl_wr && !host_inc && sap_idx == 7'(i), wdata_s2_q,
          host_inc && sap_idx == 7'(i),
          seq_hdr && chk_wr && hdr_slot == 7'(i), chk_ctrl,
          seq_ind && ind_slot == 7'(i));
        if (wr_evt && is_sap && sap_idx == 7'(i) && sap_sel == 2'h1)
          src_q[i] <= wdata_s2_q;
        if (wr_evt && is_sap && sap_idx == 7'(i) && sap_sel == 2'h2)
          ptr_q[i] <= wdata_s2_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read data

  wire [3:0] las_rd = is_las ? las_q[las_idx] : 4'h0;
  wire [7:0] sap_rd = !is_sap ? 8'h00
    : (sap_sel == 2'h0) ? ctrl_q[sap_idx]
    : (sap_sel == 2'h1) ? src_q[sap_idx] : ptr_q[sap_idx];
  wire [7:0] status_rd = 8'(lock_value) << `STATUS_LOCK_BIT;
  wire [7:0] rd_mux = is_lock ? {7'h00, lock_value}
    : is_status ? status_rd
    : is_las ? {2'h0, las_rd, 2'h0}
    : sap_rd;

  // data is captured at the strobe edge and driven until release
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
    end
    else if (rd_evt)
    begin
      host_data_out <= rd_mux;
      host_data_oe <= 1'b1;
    end
    else if (strb_s2_q[0])
      host_data_oe <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // replies, indication pointer and host events

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resp_valid <= 1'b0;
      resp_code <= sram_lock_pkg::RESP_OK;
      ind_wp <= 8'h00;
      las_change_evt <= 1'b0;
      ind_evt <= 1'b0;
    end
    else
    begin
      resp_valid <= seq_hdr;
      if (seq_hdr)
        resp_code <= chk_code;
      if (seq_ind && ind_supported)
        ind_wp <= ind_wp + 8'h01;
      ind_evt <= seq_ind && ind_supported;
      las_change_evt <= stn_moved;
    end
  end

endmodule

// *** sram_lock_map.svh ***
// register offsets, field positions, reset values and codes of the lock block
`ifndef SRAM_LOCK_MAP_SVH
`define SRAM_LOCK_MAP_SVH

// host address map
`define LOCK_CELL_ADDR 10'h318
`define STATUS_ADDR 10'h31e
`define STATUS_LOCK_BIT 0
`define LAS_BASE_ADDR 10'h020
`define LAS_LAST_ADDR 10'h09e
`define SAP_BASE_ADDR 10'h0a0
`define SAP_ENTRY_BYTES 3

// station entry fields
`define LAS_FCB_BIT 5
`define LAS_FCV_BIT 4
`define LAS_CHANGE_BIT 3
`define LAS_STATE_BIT 2

// service point control byte fields
`define CTRL_LOCKED_BIT 7
`define CTRL_NO_SERVICE_BIT 6
`define CTRL_USER_ERROR_BIT 5
`define CTRL_NO_RESOURCE_BIT 4
`define CTRL_IN_USE_BIT 3
`define CTRL_COUNT_MAX 3'h7

// special values and reset values
`define SRC_INACTIVE 8'h7f
`define CTRL_INC_CODE 8'hff
`define CTRL_RESET 8'h00
`define SRC_RESET 8'h7f
`define PTR_RESET 8'h00
`define LAS_RESET 4'h0

`endif

// *** sram_lock_pkg.sv ***
// types shared by the lock, station list and service point logic
package sram_lock_pkg;

  // reply chosen for a received header
  typedef enum logic [2:0] {
    RESP_OK = 3'h0,
    RESP_NO_SERVICE = 3'h1,
    RESP_USER_ERROR = 3'h2,
    RESP_NO_RESOURCE = 3'h3
  } resp_code_t;

  // owner of the shared ram
  typedef enum logic [2:0] {
    LK_FREE = 3'b001,
    LK_HOST = 3'b010,
    LK_SEQ = 3'b100
  } lock_state_t;

endpackage

// *** lock_arbiter.sv ***
// owner tracking of the shared ram between host and sequencer
`timescale 1ns/1ps
module lock_arbiter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host side strobes
  input wire logic lock_read,
  input wire logic lock_write,
  // sequencer side
  input wire logic seq_req,
  output logic seq_grant,
  // lock state
  output logic host_lock,
  output logic read_value
);

  sram_lock_pkg::lock_state_t state_q;
  sram_lock_pkg::lock_state_t state_d;

  // value shown by the cell
  // one-hot code: each owner is a flop bit, so outputs need no gates
  assign read_value = state_q[2];
  assign host_lock = state_q[1];
  assign seq_grant = state_q[2];

  // next owner; host read wins a tie with a free ram
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sram_lock_pkg::LK_FREE:
      begin
        if (lock_read)
          state_d = sram_lock_pkg::LK_HOST;
        else if (seq_req)
          state_d = sram_lock_pkg::LK_SEQ;
      end
      sram_lock_pkg::LK_HOST:
      begin
        if (lock_write)
          state_d = sram_lock_pkg::LK_FREE;
      end
      sram_lock_pkg::LK_SEQ:
      begin
        if (!seq_req)
          state_d = sram_lock_pkg::LK_FREE;
      end
      default: state_d = sram_lock_pkg::LK_FREE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_q <= sram_lock_pkg::LK_FREE;
    else
      state_q <= state_d;
  end

endmodule

// *** sap_checker.sv ***
// admission check of a received header against its service point entry
`timescale 1ns/1ps
`include "sram_lock_map.svh"
module sap_checker #(
  parameter int SAPS = 64
) (
  // entry of the addressed service point
  input wire logic [7:0] ctrl,
  input wire logic [7:0] exp_src,
  // received header
  input wire logic [6:0] sap_num,
  input wire logic is_default,
  input wire logic [7:0] src_addr,
  input wire logic queue_full,
  input wire logic [5:0] sap_max,
  // verdict
  output sram_lock_pkg::resp_code_t code,
  output logic entry_wr,
  output logic [7:0] new_ctrl
);

  logic missing;
  logic exceeded;
  logic src_bad;
  logic no_buf;

  assign missing = !is_default && (sap_num >= 7'(SAPS));
  assign exceeded = !is_default && (sap_num[5:0] > sap_max);
  assign src_bad = (exp_src == `SRC_INACTIVE) || (exp_src != src_addr);
  assign no_buf = (ctrl[2:0] == 3'h0) || queue_full;

  // priority: existence, limit, lock, source, resources
  always_comb
  begin
    new_ctrl = ctrl;
    entry_wr = !missing;
    code = sram_lock_pkg::RESP_OK;
    if (missing)
      code = sram_lock_pkg::RESP_NO_SERVICE;
    else if (exceeded)
    begin
      code = sram_lock_pkg::RESP_NO_SERVICE;
      new_ctrl[`CTRL_NO_SERVICE_BIT] = 1'b1;
    end
    else if (ctrl[`CTRL_LOCKED_BIT])
    begin
      code = sram_lock_pkg::RESP_USER_ERROR;
      new_ctrl[`CTRL_USER_ERROR_BIT] = 1'b1;
    end
    else if (src_bad)
    begin
      code = sram_lock_pkg::RESP_NO_SERVICE;
      new_ctrl[`CTRL_NO_SERVICE_BIT] = 1'b1;
    end
    else if (no_buf)
    begin
      code = sram_lock_pkg::RESP_NO_RESOURCE;
      new_ctrl[`CTRL_NO_RESOURCE_BIT] = 1'b1;
    end
    else
    begin
      new_ctrl[`CTRL_IN_USE_BIT] = 1'b1;
    end
  end

endmodule

// *** lock_props.sv ***
// checker of lock, list and indication behaviour at the block ports
`timescale 1ns/1ps
module lock_props #(
  parameter int STATIONS = 127,
  parameter int SAPS = 64
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host strobe and bus enable
  input wire logic host_rd_n,
  input wire logic host_data_oe,
  // sequencer lock
  input wire logic seq_lock_req,
  input wire logic seq_lock_grant,
  // sequencer requests
  input wire logic stn_valid,
  input wire logic hdr_valid,
  input wire logic [6:0] hdr_sap,
  input wire logic hdr_default,
  input wire logic ind_valid,
  input wire logic ind_supported,
  // replies and events
  input wire logic resp_valid,
  input wire sram_lock_pkg::resp_code_t resp_code,
  input wire logic [7:0] ind_wp,
  input wire logic las_change_evt,
  input wire logic ind_evt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // replies follow an accepted header by exactly one cycle
  a_hdr_gets_resp: assert property (
    hdr_valid && seq_lock_grant |=> resp_valid)
    else $error("header without reply");
  a_resp_has_cause: assert property (
    resp_valid |-> $past(hdr_valid && seq_lock_grant))
    else $error("reply without header");
  // missing points answer no service whatever their entry holds
  a_missing_no_svc: assert property (
    hdr_valid && seq_lock_grant && !hdr_default && int'(hdr_sap) >= SAPS
    |=> resp_code == sram_lock_pkg::RESP_NO_SERVICE)
    else $error("missing point not refused");
  // ownership only ever follows a request
  a_grant_needs_req: assert property (
    seq_lock_grant |-> $past(seq_lock_req))
    else $error("grant without request");
  // indication pointer moves only for supported services
  a_ind_ptr_step: assert property (
    ind_valid && seq_lock_grant && ind_supported
    |=> ind_evt && ind_wp == $past(ind_wp) + 8'h01)
    else $error("pointer not advanced");
  a_unsup_quiet: assert property (
    ind_valid && seq_lock_grant && !ind_supported
    |=> !ind_evt && $stable(ind_wp))
    else $error("unsupported service signalled");
  a_las_evt_cause: assert property (
    las_change_evt |-> $past(stn_valid && seq_lock_grant))
    else $error("station event without update");
  // the synchroniser delay bounds how long the bus stays driven
  a_oe_release: assert property (
    $rose(host_rd_n) |-> ##[1:6] !host_data_oe)
    else $error("data bus left driven");
  // main scenarios
  c_no_res: cover property (
    resp_valid && resp_code == sram_lock_pkg::RESP_NO_RESOURCE);
  c_ind: cover property (ind_evt);
  c_las: cover property (las_change_evt);
endmodule
bind shared_ram_lock_station_sap_lists lock_props #(
  .STATIONS(STATIONS), .SAPS(SAPS)) u_props (.ref_clk, .rst, .host_rd_n,
  .host_data_oe, .seq_lock_req, .seq_lock_grant, .stn_valid, .hdr_valid,
  .hdr_sap, .hdr_default, .ind_valid, .ind_supported, .resp_valid,
  .resp_code, .ind_wp, .las_change_evt, .ind_evt);

// *** host_port_model.sv ***
// host controller model on the parallel register and ram port
`timescale 1ns/1ps
module host_port_model (
  // clock
  input wire logic ref_clk,
  // parallel port
  output logic [9:0] host_addr,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out
);
  ////////////////////////////////////////////////////////////////////////
  // idle bus at time zero, strobes inactive
  initial
  begin
    host_addr = 10'h000;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_data_in = 8'h00;
  end
  // one byte access; address settles 3 cycles before the strobe
  task automatic xfer(input logic wr, input logic [9:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    host_addr <= a;
    host_data_in <= d;
    repeat (3) @(posedge ref_clk);
    host_rd_n <= wr;
    host_wr_n <= !wr;
    repeat (6) @(posedge ref_clk);
    q = host_data_out;
    host_rd_n <= 1'b1;
    host_wr_n <= 1'b1;
    // released data lines show the inverse, never the last byte
    host_data_in <= ~d;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic take_lock();
    logic [7:0] q;
    int n;
    q = 8'h01;
    for (n = 0; n < 16 && q[0] !== 1'b0; n++)
      xfer(1'b0, 10'h318, 8'h00, q);
  endtask
  task automatic drop_lock();
    logic [7:0] q;
    xfer(1'b1, 10'h318, 8'h5a, q);
  endtask
endmodule

// *** tb_top.sv ***
// self-checking bench of the lock, station list and service point block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] host_addr;
  logic host_rd_n, host_wr_n, host_data_oe, seq_lock_grant;
  logic [7:0] host_data_in, host_data_out, ind_wp;
  logic seq_lock_req = 1'b0, stn_valid = 1'b0, stn_in_ring = 1'b0;
  logic stn_fcb = 1'b0, stn_fcv = 1'b0, hdr_valid = 1'b0;
  logic hdr_default = 1'b0, hdr_queue_full = 1'b0, ind_valid = 1'b0;
  logic ind_default = 1'b0, ind_supported = 1'b0;
  logic [6:0] stn_addr = 7'h00, hdr_sap = 7'h00;
  logic [7:0] hdr_src_addr = 8'h00;
  logic [5:0] sap_max = 6'h3f, ind_sap = 6'h02;
  logic resp_valid, las_change_evt, ind_evt;
  sram_lock_pkg::resp_code_t resp_code;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // clock, and a ceiling that cuts a hang short
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  shared_ram_lock_station_sap_lists dut (.ref_clk, .rst, .host_addr,
    .host_rd_n, .host_wr_n, .host_data_in, .host_data_out, .host_data_oe,
    .seq_lock_req, .seq_lock_grant, .stn_valid, .stn_addr, .stn_in_ring,
    .stn_fcb, .stn_fcv, .hdr_valid, .hdr_sap, .hdr_default, .hdr_src_addr,
    .hdr_queue_full, .sap_max, .resp_valid, .resp_code, .ind_valid,
    .ind_sap, .ind_default, .ind_supported, .ind_wp, .las_change_evt,
    .ind_evt);
  host_port_model hm (.ref_clk, .host_addr, .host_rd_n, .host_wr_n,
    .host_data_in, .host_data_out);
  // comparison and host access helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    hm.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
    chk({7'h00, host_data_oe}, 8'h00);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    hm.xfer(1'b1, a, d, q);
  endtask
  // sequencer ownership; entered and left on a rising edge
  task automatic seq_on();
    int n;
    seq_lock_req <= 1'b1;
    for (n = 0; n < 20 && seq_lock_grant !== 1'b1; n++)
      @(negedge ref_clk);
    chk({7'h00, seq_lock_grant}, 8'h01);
    @(posedge ref_clk);
  endtask
  task automatic seq_off();
    seq_lock_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic hdr(input logic [6:0] s, input logic d,
      input logic [7:0] src, input logic qf, input logic [2:0] e);
    hdr_valid <= 1'b1;
    hdr_sap <= s;
    hdr_default <= d;
    hdr_src_addr <= src;
    hdr_queue_full <= qf;
    @(posedge ref_clk);
    hdr_valid <= 1'b0;
    @(negedge ref_clk);
    chk({7'h00, resp_valid}, 8'h01);
    chk({5'h00, resp_code}, {5'h00, e});
    @(posedge ref_clk);
  endtask
  task automatic ind(input logic sup, input logic [7:0] wp);
    ind_valid <= 1'b1;
    ind_supported <= sup;
    @(posedge ref_clk);
    ind_valid <= 1'b0;
    @(negedge ref_clk);
    chk({7'h00, ind_evt}, {7'h00, sup});
    chk(ind_wp, wp);
    @(posedge ref_clk);
  endtask
  task automatic stn(input logic [6:0] a, input logic ring, input logic e);
    stn_valid <= 1'b1;
    stn_addr <= a;
    stn_in_ring <= ring;
    stn_fcb <= ring;
    stn_fcv <= ring;
    @(posedge ref_clk);
    stn_valid <= 1'b0;
    @(negedge ref_clk);
    chk({7'h00, las_change_evt}, {7'h00, e});
    @(posedge ref_clk);
  endtask
  // scenarios
  task automatic t_reset();
    rd(10'h0a0, 8'h00);
    rd(10'h0a1, 8'h7f);
    rd(10'h0a2, 8'h00);
    rd(10'h020, 8'h00);
    rd(10'h31e, 8'h00);
  endtask
  task automatic t_lock();
    rd(10'h318, 8'h00);
    seq_lock_req <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk({7'h00, seq_lock_grant}, 8'h00);
    hm.drop_lock();
    seq_on();
    rd(10'h318, 8'h01);
    rd(10'h31e, 8'h01);
  endtask
  task automatic t_station();
    stn(7'h7e, 1'b1, 1'b1);
    stn(7'h7f, 1'b1, 1'b0);
    seq_off();
    rd(10'h09e, 8'h3c);
    hm.take_lock();
    wr(10'h09e, 8'h34);
    hm.drop_lock();
    rd(10'h09e, 8'h34);
    seq_on();
    stn(7'h7e, 1'b0, 1'b1);
    seq_off();
    rd(10'h09e, 8'h08);
  endtask
  task automatic t_sap();
    hm.take_lock();
    wr(10'h0a9, 8'h01);
    wr(10'h0aa, 8'h11);
    hm.drop_lock();
    seq_on();
    hdr(7'h02, 1'b0, 8'h11, 1'b0, 3'h0);
    ind(1'b1, 8'h01);
    hdr(7'h02, 1'b0, 8'h11, 1'b0, 3'h3);
    hdr(7'h02, 1'b0, 8'h12, 1'b0, 3'h1);
    hdr(7'h40, 1'b0, 8'h11, 1'b0, 3'h1);
    hdr(7'h00, 1'b1, 8'h11, 1'b0, 3'h1);
    sap_max <= 6'h01;
    hdr(7'h02, 1'b0, 8'h11, 1'b0, 3'h1);
    sap_max <= 6'h3f;
    ind(1'b0, 8'h01);
    seq_off();
    rd(10'h0a9, 8'h50);
    rd(10'h0a0, 8'h40);
    wr(10'h0a9, 8'hff);
    rd(10'h0a9, 8'h51);
    seq_on();
    hdr(7'h02, 1'b0, 8'h11, 1'b1, 3'h3);
    seq_off();
    hm.take_lock();
    wr(10'h0a9, 8'h80);
    hm.drop_lock();
    seq_on();
    hdr(7'h02, 1'b0, 8'h11, 1'b0, 3'h2);
    seq_off();
    rd(10'h0a9, 8'ha0);
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence after a six cycle reset
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_lock();
    t_station();
    t_sap();
    stop_test();
  end
endmodule
